/* File: rtl/rire_exec.sv */
// Execution of the software reset and the interrupt-return instructions.
// Assumes opcodes arrive at phase Q1 from the core on sys_clk, and that the
// core's stack supplies its top entry and pops on request.
`timescale 1ns/100ps
`default_nettype none
`include "rire_regs.svh"

module rire_exec
    import rire_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic external_master_clear_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [20:0] return_stack_top,
    input wire logic priority_mode,
    input wire logic irq_was_high,
    input wire logic irq_entry,
    input wire logic irq_entry_high,
    input wire logic acc_wr,
    input wire logic [7:0] acc_wdata,
    input wire logic flags_wr,
    input wire logic [7:0] flags_wdata,
    input wire logic bank_wr,
    input wire logic [3:0] bank_wdata,
    input wire logic latu_wr,
    input wire logic [4:0] latu_wdata,
    input wire logic lath_wr,
    input wire logic [7:0] lath_wdata,
    output logic [1:0] q_phase,
    output logic [7:0] accumulator,
    output logic [7:0] flags,
    output logic [3:0] bank_selector,
    output logic [7:0] accumulator_shadow,
    output logic [7:0] flags_shadow,
    output logic [3:0] bank_selector_shadow,
    output logic high_priority_irq_enable,
    output logic low_priority_irq_enable,
    output logic [4:0] pc_upper_hold_latch,
    output logic [7:0] pc_high_hold_latch,
    output logic [20:0] pc_value,
    output logic pc_load,
    output logic stack_pop,
    output logic soft_reset,
    output logic pipe_flush
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_reset_op(input logic [15:0] w);
        is_reset_op = (w == `RIRE_OP_RESET);
    endfunction

    function automatic logic is_return_op(input logic [15:0] w);
        is_return_op = ((w & `RIRE_OP_RET_MASK) == `RIRE_OP_RET_BASE);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    rire_state_s_t state_reg;
    rire_state_s_t state_next;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.pc_load = 1'b0;
        state_next.pop = 1'b0;
        state_next.soft_rst = 1'b0;

        // Master clear pin through two flops
        state_next.external_master_clear_s1 = external_master_clear_n;
        state_next.external_master_clear_s2 = state_reg.external_master_clear_s1;

        state_next.q = state_reg.q + `RIRE_Q_STEP;

        // Ordinary writes from the rest of the core
        if (acc_wr) begin
            state_next.acc = acc_wdata;
        end
        if (flags_wr) begin
            state_next.flags = flags_wdata;
        end
        if (bank_wr) begin
            state_next.bank = bank_wdata;
        end
        if (latu_wr) begin
            state_next.latu = latu_wdata;
        end
        if (lath_wr) begin
            state_next.lath = lath_wdata;
        end

        // Interrupt entry saves the live context and masks further entry
        if (irq_entry) begin
            state_next.acc_sh = state_reg.acc;
            state_next.flags_sh = state_reg.flags;
            state_next.bank_sh = state_reg.bank;
            if (priority_mode && !irq_entry_high) begin
                state_next.gie_l = 1'b0;
            end else begin
                state_next.gie_h = 1'b0;
            end
        end

        case (state_reg.st)
            RIRE_RUN: begin
                if (state_reg.q == `RIRE_Q1) begin
                    state_next.ir = instr_word;
                    state_next.ir_valid = instr_valid;
                end
                if (state_reg.ir_valid && state_reg.q == `RIRE_Q2 &&
                    is_reset_op(state_reg.ir)) begin
                    state_next.soft_rst = 1'b1; // [RL5]
                end
                if (state_reg.ir_valid && state_reg.q == `RIRE_Q4 &&
                    is_return_op(state_reg.ir)) begin
                    // Only the PC is reloaded; latches are left as they are
                    state_next.pc = return_stack_top; // [RL4]
                    state_next.pc_load = 1'b1;
                    state_next.pop = 1'b1;
                    if (priority_mode && !irq_was_high) begin
                        state_next.gie_l = 1'b1; // [RL2]
                    end else begin
                        state_next.gie_h = 1'b1; // [RL2]
                    end
                    if (state_reg.ir[`RIRE_RET_S_BIT]) begin
                        state_next.acc = state_reg.acc_sh; // [RL3]
                        state_next.flags = state_reg.flags_sh; // [RL3]
                        state_next.bank = state_reg.bank_sh; // [RL3]
                    end
                    state_next.ir_valid = 1'b0;
                    state_next.flush = 1'b1; // [RL5]
                    state_next.st = RIRE_FLUSH; // [RL5]
                end
            end
            RIRE_FLUSH: begin
                // Refetch cycle: opcode presented now is dropped
                state_next.ir_valid = 1'b0;
                if (state_reg.q == `RIRE_Q4) begin
                    state_next.flush = 1'b0; // [RL5]
                    state_next.st = RIRE_RUN;
                end
            end
            default: begin
                state_next.st = RIRE_RUN;
                state_next.flush = 1'b0;
            end
        endcase

        // Software reset or master clear: same values everywhere
        if (state_reg.soft_rst || !state_reg.external_master_clear_s2) begin
            state_next.q = `RIRE_Q1; // [RL1]
            state_next.st = RIRE_RUN; // [RL1]
            state_next.ir = `RIRE_IR_RST;
            state_next.ir_valid = 1'b0; // [RL1]
            state_next.acc = `RIRE_ACC_RST; // [RL1]
            state_next.flags = `RIRE_FLAGS_RST; // [RL1]
            state_next.bank = `RIRE_BANK_RST; // [RL1]
            state_next.acc_sh = `RIRE_ACC_RST; // [RL1]
            state_next.flags_sh = `RIRE_FLAGS_RST; // [RL1]
            state_next.bank_sh = `RIRE_BANK_RST; // [RL1]
            state_next.gie_h = 1'b0; // [RL1]
            state_next.gie_l = 1'b0; // [RL1]
            state_next.latu = `RIRE_LATU_RST; // [RL1]
            state_next.lath = `RIRE_LATH_RST; // [RL1]
            state_next.pc = `RIRE_PC_RST; // [RL1]
            state_next.pc_load = 1'b0;
            state_next.pop = 1'b0;
            state_next.flush = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg.q <= `RIRE_Q1;
            state_reg.st <= RIRE_RUN;
            state_reg.ir <= `RIRE_IR_RST;
            state_reg.ir_valid <= 1'b0;
            state_reg.acc <= `RIRE_ACC_RST;
            state_reg.flags <= `RIRE_FLAGS_RST;
            state_reg.bank <= `RIRE_BANK_RST;
            state_reg.acc_sh <= `RIRE_ACC_RST;
            state_reg.flags_sh <= `RIRE_FLAGS_RST;
            state_reg.bank_sh <= `RIRE_BANK_RST;
            state_reg.gie_h <= 1'b0;
            state_reg.gie_l <= 1'b0;
            state_reg.latu <= `RIRE_LATU_RST;
            state_reg.lath <= `RIRE_LATH_RST;
            state_reg.pc <= `RIRE_PC_RST;
            state_reg.pc_load <= 1'b0;
            state_reg.pop <= 1'b0;
            state_reg.soft_rst <= 1'b0;
            state_reg.flush <= 1'b0;
            state_reg.external_master_clear_s1 <= 1'b1;
            state_reg.external_master_clear_s2 <= 1'b1;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign q_phase = state_reg.q;
    assign accumulator = state_reg.acc;
    assign flags = state_reg.flags;
    assign bank_selector = state_reg.bank;
    assign accumulator_shadow = state_reg.acc_sh;
    assign flags_shadow = state_reg.flags_sh;
    assign bank_selector_shadow = state_reg.bank_sh;
    assign high_priority_irq_enable = state_reg.gie_h;
    assign low_priority_irq_enable = state_reg.gie_l;
    assign pc_upper_hold_latch = state_reg.latu;
    assign pc_high_hold_latch = state_reg.lath;
    assign pc_value = state_reg.pc;
    assign pc_load = state_reg.pc_load;
    assign stack_pop = state_reg.pop;
    assign soft_reset = state_reg.soft_rst;
    assign pipe_flush = state_reg.flush;

endmodule // rire_exec

`default_nettype wire

/* File: rtl/rire_pkg.sv */
// Types for the reset and interrupt-return execution block.
// Assumes nothing beyond the constants header.
package rire_pkg;

    typedef enum logic [1:0] {
        RIRE_RUN,
        RIRE_FLUSH
    } rire_state_t;

    typedef struct packed {
        logic [1:0] q;
        rire_state_t st;
        logic [15:0] ir;
        logic ir_valid;
        logic [7:0] acc;
        logic [7:0] flags;
        logic [3:0] bank;
        logic [7:0] acc_sh;
        logic [7:0] flags_sh;
        logic [3:0] bank_sh;
        logic gie_h;
        logic gie_l;
        logic [4:0] latu;
        logic [7:0] lath;
        logic [20:0] pc;
        logic pc_load;
        logic pop;
        logic soft_rst;
        logic flush;
        logic external_master_clear_s1;
        logic external_master_clear_s2;
    } rire_state_s_t;

endpackage

/* File: rtl/rire_regs.svh */
// Constants for the reset and interrupt-return execution block.
// Assumes the core supplies opcodes already fetched, on sys_clk.
// Operation
// RL1 - Software reset returns every register and flag to master-clear values.
// RL2 - Interrupt return sets the high or low priority global enable.
// RL3 - Option bit one restores accumulator, flags, bank selector from shadows.
// RL4 - Interrupt return reloads only PC; both holding latches keep their values.
// RL5 - Return takes two cycles, second a no-op; reset starts after one.
`ifndef RIRE_REGS_SVH
`define RIRE_REGS_SVH

// Opcodes
`define RIRE_OP_RESET 16'h00FF
`define RIRE_OP_RET_BASE 16'h0010
`define RIRE_OP_RET_MASK 16'hFFFE
`define RIRE_RET_S_BIT 0

// Phases of one instruction cycle
`define RIRE_Q1 2'h0
`define RIRE_Q2 2'h1
`define RIRE_Q3 2'h2
`define RIRE_Q4 2'h3
`define RIRE_Q_STEP 2'h1

// Reset values
`define RIRE_ACC_RST 8'h00
`define RIRE_FLAGS_RST 8'h00
`define RIRE_BANK_RST 4'h0
`define RIRE_LATU_RST 5'h00
`define RIRE_LATH_RST 8'h00
`define RIRE_PC_RST 21'h000000
`define RIRE_IR_RST 16'h0000

`endif

/* File: sim/rire_exec_sva.sv */
// Assertion checker for the reset and interrupt-return execution block.
// Assumes it is bound to rire_exec and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "rire_regs.svh"
module rire_exec_sva (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic priority_mode,
    input wire logic irq_was_high,
    input wire logic acc_wr,
    input wire logic lath_wr,
    input wire logic high_priority_irq_enable,
    input wire logic low_priority_irq_enable,
    input wire logic pc_load,
    input wire logic stack_pop,
    input wire logic soft_reset,
    input wire logic pipe_flush,
    input wire logic [1:0] q_phase,
    input wire logic [15:0] instr_word,
    input wire logic [20:0] return_stack_top,
    input wire logic [20:0] pc_value,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] accumulator_shadow,
    input wire logic [7:0] pc_high_hold_latch
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ----
    // Opcode capture at Q1
    // ----
    sequence cap_rst;
        ce && q_phase == `RIRE_Q1 && !pipe_flush && instr_valid
            && instr_word == `RIRE_OP_RESET;
    endsequence
    sequence ret_cap;
        ce && q_phase == `RIRE_Q1 && !pipe_flush && instr_valid
            && (instr_word & `RIRE_OP_RET_MASK) == `RIRE_OP_RET_BASE;
    endsequence
    chk_reset_start: assert property (cap_rst ##1 ce |=> soft_reset)
        else $error("software reset pulse late");
    chk_reset_clear: assert property (soft_reset && ce |=> accumulator == `RIRE_ACC_RST
        && pc_value == `RIRE_PC_RST && pc_high_hold_latch == `RIRE_LATH_RST
        && !high_priority_irq_enable && !low_priority_irq_enable)
        else $error("registers not cleared by software reset");
    chk_ret_pop: assert property (ret_cap ##1 ce[*3] |=> pc_load && stack_pop
        && pipe_flush && pc_value == $past(return_stack_top))
        else $error("return did not reload pc at Q4");
    chk_ret_enable: assert property (ret_cap ##1 ce[*3] |=>
        (($past(priority_mode) && !$past(irq_was_high)) ? low_priority_irq_enable
        : high_priority_irq_enable)) else $error("return did not set enable");
    chk_shadow_restore: assert property (ret_cap ##0 instr_word[0] ##1 ce[*3]
        |=> accumulator == $past(accumulator_shadow)) else $error("shadow not restored");
    chk_no_restore: assert property (ret_cap ##0 !instr_word[0] ##1 ce[*3] ##0 !acc_wr
        |=> $stable(accumulator)) else $error("accumulator altered with option zero");
    chk_latch_keep: assert property (pc_load && !$past(lath_wr)
        |-> $stable(pc_high_hold_latch)) else $error("holding latch changed on return");
    chk_flush_len: assert property ($rose(pipe_flush) ##0 ce[*4] |=> !pipe_flush)
        else $error("flush not one instruction cycle");
    chk_pulse_once: assert property (pc_load && ce |=> !pc_load && !stack_pop)
        else $error("pc load pulse too long");
endmodule // rire_exec_sva
bind rire_exec rire_exec_sva rire_exec_sva_i (.*);
`default_nettype wire

/* File: sim/rire_exec_tb_top.sv */
// Self-checking testbench for the reset and interrupt-return execution block.
// Assumes rire_exec with the checker bound; scenarios drive clock enable and clear pin.
`timescale 1ns/100ps
`default_nettype none
`include "rire_regs.svh"
module rire_exec_tb_top;
    logic sys_clk = 1'b0;
    logic nrst, ce, external_master_clear_n, instr_valid, priority_mode, irq_was_high;
    logic irq_entry, irq_entry_high, acc_wr, flags_wr, bank_wr, latu_wr, lath_wr;
    logic [15:0] instr_word;
    logic [20:0] return_stack_top, pc_value;
    logic [7:0] acc_wdata, flags_wdata, lath_wdata, accumulator, flags, accumulator_shadow;
    logic [7:0] flags_shadow, pc_high_hold_latch;
    logic [3:0] bank_wdata, bank_selector, bank_selector_shadow;
    logic [4:0] latu_wdata, pc_upper_hold_latch;
    logic [1:0] q_phase;
    logic high_priority_irq_enable, low_priority_irq_enable, pc_load, stack_pop;
    logic soft_reset, pipe_flush;
    int fails = 0;
    int num_checks = 0;
    rire_exec rire_exec_i (.*);
    always #5 sys_clk = ~sys_clk;
    // ----
    // Shared tasks
    // ----
    task chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [7:0] v);
        {acc_wr, flags_wr, bank_wr, latu_wr, lath_wr} = 5'h1F;
        {acc_wdata, flags_wdata, lath_wdata} = {3{v}};
        bank_wdata = v[3:0];
        latu_wdata = v[4:0];
        tick(1);
        {acc_wr, flags_wr, bank_wr, latu_wr, lath_wr} = 5'h00;
    endtask
    task issue(input logic [15:0] w);
        while (q_phase !== `RIRE_Q1) tick(1);
        instr_word = w;
        instr_valid = 1'b1;
        tick(1);
        instr_valid = 1'b0;
    endtask
    task end_of_test;
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task t_ret_restore;
        wr(8'hA5);
        irq_entry = 1'b1;
        tick(1);
        irq_entry = 1'b0;
        wr(8'h3C);
        return_stack_top = 21'h1ABCDE;
        issue(16'h0011);
        tick(3);
        chk(pc_value, 21'h1ABCDE);
        chk({pc_load, stack_pop, pipe_flush}, 3'h7);
        chk(high_priority_irq_enable, 1'b1);
        chk({accumulator, flags, bank_selector}, 20'hA5A55);
        chk({pc_upper_hold_latch, pc_high_hold_latch}, {5'h1C, 8'h3C});
        instr_word = `RIRE_OP_RESET;
        instr_valid = 1'b1;
        tick(1);
        instr_valid = 1'b0;
        chk({pc_load, pipe_flush}, 2'h1);
        tick(1);
        chk(soft_reset, 1'b0);
        tick(2);
        chk(pipe_flush, 1'b0);
    endtask
    task t_ret_plain;
        priority_mode = 1'b1;
        wr(8'h5A);
        return_stack_top = 21'h0F0F0F;
        issue(`RIRE_OP_RET_BASE);
        tick(3);
        chk({accumulator, bank_selector}, 12'h5AA);
        chk({low_priority_irq_enable, pc_value}, {1'b1, 21'h0F0F0F});
        tick(4);
    endtask
    task t_soft_reset;
        wr(8'hC3);
        issue(`RIRE_OP_RESET);
        tick(1);
        chk(soft_reset, 1'b1);
        tick(1);
        chk({accumulator, flags, bank_selector, accumulator_shadow, flags_shadow}, 36'h0);
        chk(bank_selector_shadow, 4'h0);
        chk({high_priority_irq_enable, low_priority_irq_enable}, 2'h0);
        chk({pc_upper_hold_latch, pc_high_hold_latch, pc_value, q_phase}, 36'h0);
    endtask
    task t_prio_high;
        irq_was_high = 1'b1;
        return_stack_top = 21'h012345;
        issue(`RIRE_OP_RET_BASE);
        ce = 1'b0;
        tick(2);
        chk(q_phase, 2'h1);
        ce = 1'b1;
        tick(2);
        chk(pc_load, 1'b0);
        tick(1);
        chk({high_priority_irq_enable, low_priority_irq_enable}, 2'h2);
        chk(pc_value, 21'h012345);
        tick(4);
        chk(pipe_flush, 1'b0);
        irq_entry = 1'b1;
        irq_entry_high = 1'b1;
        tick(1);
        {irq_entry, irq_entry_high, irq_was_high} = 3'h0;
        chk({high_priority_irq_enable, low_priority_irq_enable}, 2'h0);
    endtask
    task t_master_clear;
        wr(8'h96);
        external_master_clear_n = 1'b0;
        tick(2);
        chk(accumulator, 8'h96);
        tick(1);
        chk({accumulator, flags, bank_selector}, 20'h0);
        chk({pc_upper_hold_latch, pc_high_hold_latch, pc_value}, 34'h0);
        chk({high_priority_irq_enable, low_priority_irq_enable, q_phase}, 4'h0);
        external_master_clear_n = 1'b1;
        tick(3);
        chk(q_phase, 2'h1);
    endtask
    initial begin
        {nrst, instr_valid, priority_mode, irq_was_high, irq_entry, irq_entry_high} = 6'h00;
        {acc_wr, flags_wr, bank_wr, latu_wr, lath_wr} = 5'h00;
        {ce, external_master_clear_n} = 2'h3;
        {acc_wdata, flags_wdata, lath_wdata, bank_wdata, latu_wdata} = 33'h0;
        instr_word = 16'h0000;
        return_stack_top = 21'h000000;
        tick(5);
        nrst = 1'b1;
        t_ret_restore;
        t_ret_plain;
        t_soft_reset;
        t_prio_high;
        t_master_clear;
        end_of_test;
    end
    initial begin
        #20000;
        fails++;
        end_of_test;
    end
endmodule // rire_exec_tb_top
`default_nettype wire
